// ---- hw/qdu_update_ctrl.sv ----
// Update control of a quad 16-bit converter: serial frames, double
// buffered codes, calibration codes, gain bits and resets.
// Assumes all pin inputs are asynchronous to mclk and far slower.
// Overview of operation
// - Channels 0,1 group A; 2,3 group B
// - Per-channel gain code, signed -128..127
// - Per-channel zero code, signed -256..255
// - Zero step eighth LSB, gain step one
// - Calibration codes reset to zero
// - Bipolar input read as two's complement
// - Unipolar input read as straight binary
// - Readback returns data in written format
// - Group select pin high unipolar, low bipolar
// - Gain bit one is x4, zero x2
// - Gain bits reset to one
// - Valid frame writes addressed input register
// - Load updates only channels written since last
// - Strobe low: frame also loads latch
// - Strobe high: frame writes input only
// - Strobe fall or load bit loads pending
// - Reset pin clears codes, registers default
// - Serial pins ignored during reset
// - Outputs stay zero until reprogrammed
// - Soft reset bit acts as reset, self-clears
// - Power-on loads reset codes and defaults
// - 24-bit frame, MSB first, commit on rise
// - Short frames discarded
`timescale 1ns/1ps
`default_nettype none
module qdu_update_ctrl (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic dev_rst_n,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic sdi,
  input wire logic latch_load_strobe_n,
  input wire logic group_a_polarity_select,
  input wire logic group_b_polarity_select,
  output logic [3:0][15:0] latch_code,
  output qdu_pkg::qdu_eff_t [3:0] eff_code,
  output logic [3:0] gain_x4,
  output logic [3:0] chan_unipolar,
  output logic [15:0] rd_data,
  output logic rd_valid,
  output logic in_reset
);
  import qdu_pkg::*;

  // Channel select for one bank, one-hot
  function automatic logic [3:0] qdu_ch_sel(input logic [3:0] addr,
                                            input logic [1:0] bank);
    logic [3:0] sel;
    sel = '0;
    if (addr[3:2] == bank) begin
      sel[addr[1:0]] = 1'b1;
    end
    return sel;
  endfunction

  logic [PIN_W-1:0] pin_raw; // Pins gathered for sync
  logic [PIN_W-1:0] pin_s; // Synchronised pins
  logic sclk_q; // Last sclk level
  logic cs_q; // Last chip select level
  logic ldn_q; // Last strobe level
  logic sclk_fall; // Falling sclk edge
  logic cs_rise; // Chip select release
  logic strobe_fall; // Strobe falling edge
  logic hw_active; // Reset pin held low
  logic sw_rst_reg; // Soft reset bit
  logic soft_clr; // Either reset source
  logic [FRAME_W-1:0] shift_reg; // Serial shift register
  logic [CNT_W-1:0] bit_cnt_reg; // Saturating bit count
  qdu_frame_t frame; // Shift register view
  logic commit; // Complete frame ends
  logic wr; // Write frame commit
  logic rd; // Read frame commit
  logic cmd_wr; // Command word write
  logic [3:0] wr_in; // Input register hits
  logic [3:0] wr_zero; // Zero code hits
  logic [3:0] wr_gain; // Gain code hits
  logic load_evt; // Load pending latches
  logic [3:0] gain_bits_reg; // Per-channel x4 select
  logic [15:0] in_reg [4]; // Input registers
  logic [15:0] latch_reg [4]; // Output latches
  logic [3:0] pend_reg; // Written since last load
  logic signed [8:0] zcal_reg [4]; // Zero codes
  logic signed [7:0] gcal_reg [4]; // Gain codes
  qdu_chan_t [3:0] chan; // Calc inputs

  // Pin synchroniser
  assign pin_raw = {dev_rst_n, cs_n, sclk, sdi, latch_load_strobe_n,
                    group_b_polarity_select, group_a_polarity_select};
  qdu_pin_sync #(.W(PIN_W), .RST_VAL(PIN_RST)) u_sync (
    .mclk(mclk),
    .rstn(rstn),
    .din(pin_raw),
    .dout(pin_s)
  );

  // Edge history of link pins
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      sclk_q <= PIN_RST[P_SCLK];
      cs_q <= PIN_RST[P_CSN];
      ldn_q <= PIN_RST[P_LDN];
    end else begin
      sclk_q <= pin_s[P_SCLK];
      cs_q <= pin_s[P_CSN];
      ldn_q <= pin_s[P_LDN];
    end
  end

  // Edges and reset sources
  assign sclk_fall = sclk_q & ~pin_s[P_SCLK];
  assign cs_rise = ~cs_q & pin_s[P_CSN];
  assign strobe_fall = ldn_q & ~pin_s[P_LDN];
  assign hw_active = ~pin_s[P_RSTN];
  assign soft_clr = hw_active | sw_rst_reg;

  // Serial shift register and bit counter
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      shift_reg <= '0;
      bit_cnt_reg <= '0;
    end else if (soft_clr || pin_s[P_CSN]) begin
      // Link blocked in reset or between frames
      bit_cnt_reg <= '0;
    end else if (sclk_fall) begin
      // MSB first; extra bits keep the last 24
      shift_reg <= {shift_reg[FRAME_W-2:0], pin_s[P_SDI]};
      if (bit_cnt_reg != FRAME_BITS) begin
        bit_cnt_reg <= bit_cnt_reg + 1'b1;
      end
    end
  end

  // Frame decode at chip select release
  assign frame = qdu_frame_t'(shift_reg);
  assign commit = cs_rise && bit_cnt_reg == FRAME_BITS && !soft_clr;
  assign wr = commit && !frame.rw;
  assign rd = commit && frame.rw;
  assign cmd_wr = wr && frame.addr == ADDR_CMD;
  assign wr_in = wr ? qdu_ch_sel(frame.addr, BANK_IN) : 4'h0;
  assign wr_zero = wr ? qdu_ch_sel(frame.addr, BANK_ZERO) : 4'h0;
  assign wr_gain = wr ? qdu_ch_sel(frame.addr, BANK_GAIN) : 4'h0;
  assign load_evt = strobe_fall | (cmd_wr & frame.data[LATCH_LOAD_CMD_BIT]);

  // Command word: gain bits and soft reset
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      gain_bits_reg <= GAIN_BITS_RST;
      sw_rst_reg <= 1'b0;
    end else if (soft_clr) begin
      // Soft reset lasts one cycle then clears
      gain_bits_reg <= GAIN_BITS_RST;
      sw_rst_reg <= 1'b0;
    end else if (cmd_wr) begin
      gain_bits_reg <= frame.data[CMD_GAIN_LSB +: 4];
      sw_rst_reg <= frame.data[CMD_RST_BIT];
    end
  end

  // Calibration codes
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      for (int c = 0; c < 4; c++) begin
        zcal_reg[c] <= ZCAL_RST;
        gcal_reg[c] <= GCAL_RST;
      end
    end else begin
      for (int c = 0; c < 4; c++) begin
        if (soft_clr) begin
          zcal_reg[c] <= ZCAL_RST;
          gcal_reg[c] <= GCAL_RST;
        end else begin
          // Width fixes the accepted ranges
          if (wr_zero[c]) begin
            zcal_reg[c] <= signed'(frame.data[8:0]);
          end
          if (wr_gain[c]) begin
            gcal_reg[c] <= signed'(frame.data[7:0]);
          end
        end
      end
    end
  end

  // Input registers, latches and pending flags
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      for (int c = 0; c < 4; c++) begin
        in_reg[c] <= CODE_RST;
        latch_reg[c] <= CODE_RST;
      end
      pend_reg <= '0;
    end else begin
      for (int c = 0; c < 4; c++) begin
        if (soft_clr) begin
          // Zero code is 0V in either mode
          in_reg[c] <= CODE_RST;
          latch_reg[c] <= CODE_RST;
          pend_reg[c] <= 1'b0;
        end else if (wr_in[c]) begin
          in_reg[c] <= frame.data;
          if (!pin_s[P_LDN]) begin
            // Strobe held low: straight through
            latch_reg[c] <= frame.data;
            pend_reg[c] <= 1'b0;
          end else begin
            // Strobe high: wait for a load
            pend_reg[c] <= 1'b1;
          end
        end else if (load_evt && pend_reg[c]) begin
          // Only written channels reload
          latch_reg[c] <= in_reg[c];
          pend_reg[c] <= 1'b0;
        end
      end
    end
  end

  // Readback of the addressed register
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rd_data <= '0;
      rd_valid <= 1'b0;
    end else begin
      rd_valid <= rd;
      if (rd) begin
        // Sign extended as written
        if (frame.addr == ADDR_CMD) begin
          rd_data <= {12'h000, gain_bits_reg};
        end else if (frame.addr[3:2] == BANK_IN) begin
          rd_data <= in_reg[frame.addr[1:0]];
        end else if (frame.addr[3:2] == BANK_ZERO) begin
          rd_data <= 16'(zcal_reg[frame.addr[1:0]]);
        end else if (frame.addr[3:2] == BANK_GAIN) begin
          rd_data <= 16'(gcal_reg[frame.addr[1:0]]);
        end else begin
          rd_data <= 16'h0000;
        end
      end
    end
  end

  // Per-channel view for the calibration arithmetic
  always_comb begin
    for (int c = 0; c < 4; c++) begin
      chan[c].code = latch_reg[c];
      chan[c].unipolar = chan_unipolar[c];
      chan[c].gcal = gcal_reg[c];
      chan[c].zcal = zcal_reg[c];
    end
  end

  qdu_cal_calc u_calc (
    .mclk(mclk),
    .rstn(rstn),
    .chan(chan),
    .eff(eff_code)
  );

  // Outputs; group select pins set both channels
  assign chan_unipolar = {pin_s[P_POLB], pin_s[P_POLB],
                          pin_s[P_POLA], pin_s[P_POLA]};
  assign gain_x4 = gain_bits_reg;
  assign in_reset = hw_active;
  always_comb begin
    for (int c = 0; c < 4; c++) begin
      latch_code[c] = latch_reg[c];
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);

  sequence s_short_frame;
    cs_rise && bit_cnt_reg != FRAME_BITS;
  endsequence
  sequence s_write_ch0;
    wr_in[0] && !soft_clr;
  endsequence

  chk_group_mode: assert property (
    chan_unipolar[0] == chan_unipolar[1] && chan_unipolar[2] == chan_unipolar[3])
    else $error("group channels differ in mode");
  chk_gain_reset: assert property (
    soft_clr |=> gain_bits_reg == GAIN_BITS_RST)
    else $error("gain bits not set by reset");
  chk_cal_reset: assert property (
    soft_clr |=> zcal_reg[2] == 0 && gcal_reg[2] == 0)
    else $error("calibration codes not cleared");
  chk_short_drop: assert property (
    s_short_frame |=> $stable(in_reg[0]) && $stable(pend_reg))
    else $error("short frame was committed");
  chk_indiv_update: assert property (
    s_write_ch0 ##0 !pin_s[P_LDN] |=> latch_reg[0] == $past(frame.data) && !pend_reg[0])
    else $error("direct update missed latch");
  chk_simul_hold: assert property (
    s_write_ch0 ##0 pin_s[P_LDN] |=> $stable(latch_reg[0]) && pend_reg[0])
    else $error("latch changed on buffered write");
  chk_strobe_load: assert property (
    load_evt && pend_reg[1] && !wr_in[1] && !soft_clr |=> latch_reg[1] == $past(in_reg[1]))
    else $error("pending channel not loaded");
  chk_idle_hold: assert property (
    load_evt && !pend_reg[2] && !wr_in[2] && !soft_clr |=> $stable(latch_reg[2]))
    else $error("idle channel reloaded");
  chk_swrst_clear: assert property (
    $rose(sw_rst_reg) |=> !sw_rst_reg && latch_reg[3] == 0 ##1 !sw_rst_reg)
    else $error("soft reset did not act once");
  chk_hw_ignore: assert property (
    hw_active [*2] |-> bit_cnt_reg == 0 && !commit)
    else $error("link active during reset");
  chk_read_fmt: assert property (
    rd && frame.addr == {BANK_ZERO, 2'h1} |=> rd_valid && rd_data == 16'($past(zcal_reg[1])))
    else $error("readback format wrong");
endmodule // qdu_update_ctrl
`default_nettype wire

// ---- hw/qdu_pkg.sv ----
// Package for the quad converter update control: frame layout, map, defaults.
// Assumes a single 20 MHz mclk domain; all pins arrive asynchronously.
package qdu_pkg;
  // Serial frame
  localparam int FRAME_W = 24;
  localparam int CNT_W = 5;
  localparam logic [CNT_W-1:0] FRAME_BITS = 5'h18;
  // Frame: read flag, spare bits, address, data word
  typedef struct packed {
    logic rw;
    logic [2:0] spare;
    logic [3:0] addr;
    logic [15:0] data;
  } qdu_frame_t;
  // Address map: command word, then banks of four channels
  localparam logic [3:0] ADDR_CMD = 4'h0;
  localparam logic [1:0] BANK_IN = 2'h1;
  localparam logic [1:0] BANK_ZERO = 2'h2;
  localparam logic [1:0] BANK_GAIN = 2'h3;
  // Command word fields
  localparam int CMD_GAIN_LSB = 0;
  localparam int LATCH_LOAD_CMD_BIT = 6;
  localparam int CMD_RST_BIT = 7;
  // Reset values
  localparam logic [15:0] CODE_RST = 16'h0000;
  localparam logic [3:0] GAIN_BITS_RST = 4'hf;
  localparam logic signed [7:0] GCAL_RST = 8'sh00;
  localparam logic signed [8:0] ZCAL_RST = 9'sh000;
  // Calibration arithmetic
  localparam int ZERO_FRAC = 3;
  localparam int GAIN_SH_BIP = 17;
  localparam int GAIN_SH_UNI = 16;
  localparam int EFF_W = 22;
  // Pin synchroniser lanes
  localparam int PIN_W = 7;
  localparam int P_POLA = 0;
  localparam int P_POLB = 1;
  localparam int P_LDN = 2;
  localparam int P_SDI = 3;
  localparam int P_SCLK = 4;
  localparam int P_CSN = 5;
  localparam int P_RSTN = 6;
  localparam logic [PIN_W-1:0] PIN_RST = 7'h24;
  // One channel's calibration inputs
  typedef struct packed {
    logic [15:0] code;
    logic unipolar;
    logic signed [7:0] gcal;
    logic signed [8:0] zcal;
  } qdu_chan_t;
  typedef logic signed [EFF_W-1:0] qdu_eff_t;
endpackage

// ---- hw/qdu_pin_sync.sv ----
// Three-flop synchroniser bank for the asynchronous pins.
// Assumes pins change slowly compared with mclk.
`timescale 1ns/1ps
`default_nettype none
module qdu_pin_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] s1_reg; // First stage, read only by s2
  logic [W-1:0] s2_reg; // Second stage
  logic [W-1:0] s3_reg; // Third stage
  // Shift chain
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      s1_reg <= RST_VAL;
      s2_reg <= RST_VAL;
      s3_reg <= RST_VAL;
    end else begin
      s1_reg <= din;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end
  // Accept a lane only once stages two and three agree
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      dout <= RST_VAL;
    end else begin
      for (int i = 0; i < W; i++) begin
        if (s2_reg[i] == s3_reg[i]) begin
          dout[i] <= s3_reg[i];
        end
      end
    end
  end
endmodule // qdu_pin_sync
`default_nettype wire

// ---- hw/qdu_cal_calc.sv ----
// Per-channel calibrated code from latch, zero and gain codes.
// Result in eighths of an LSB, one cycle after the inputs.
`timescale 1ns/1ps
`default_nettype none
module qdu_cal_calc (
  input wire logic mclk,
  input wire logic rstn,
  input wire qdu_pkg::qdu_chan_t [3:0] chan,
  output qdu_pkg::qdu_eff_t [3:0] eff
);
  import qdu_pkg::*;
  logic signed [16:0] in_ext [4]; // Input code, signed view
  logic signed [20:0] base [4]; // Code plus zero, eighth LSB
  logic signed [28:0] prod [4]; // Base times gain code
  logic signed [28:0] corr [4]; // Gain correction
  // Arithmetic per channel
  always_comb begin
    for (int c = 0; c < 4; c++) begin
      // Straight binary or two's complement
      in_ext[c] = chan[c].unipolar ? signed'({1'b0, chan[c].code}) :
                  signed'({chan[c].code[15], chan[c].code});
      // Widen before the shift so the top code bits survive
      base[c] = (21'(in_ext[c]) <<< ZERO_FRAC) + 21'(chan[c].zcal);
      prod[c] = 29'(base[c]) * 29'(chan[c].gcal);
      corr[c] = chan[c].unipolar ? (prod[c] >>> GAIN_SH_UNI) :
                (prod[c] >>> GAIN_SH_BIP);
    end
  end
  // Registered result
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      eff <= '0;
    end else begin
      for (int c = 0; c < 4; c++) begin
        eff[c] <= EFF_W'(base[c]) + EFF_W'(corr[c]);
      end
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  // Zero calibration leaves eight times the code
  chk_eff_uncal: assert property (
    (chan[0].gcal == 0 && chan[0].zcal == 0 && !chan[0].unipolar)
      |=> eff[0] == EFF_W'(signed'($past(chan[0].code)) * 8))
    else $error("uncalibrated result wrong");
endmodule // qdu_cal_calc
`default_nettype wire

// ---- verif/qdu_host_model.sv ----
// Host side model: drives serial frames of n bits into the update control.
// Assumes mclk from the bench; pins change 2 ns after its rising edge.
`timescale 1ns/1ps
`default_nettype none
module qdu_host_model (
  input wire logic mclk,
  output logic cs_n,
  output logic sclk,
  output logic sdi
);
  // Idle: deselected, clock parked high so the first edge is a fall
  initial begin
    cs_n = 1'b1;
    sclk = 1'b1;
    sdi = 1'b0;
  end
  // Wait n cycles, then step off the edge
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #2;
  endtask
  // Send the low n bits of w, MSB first, one clock fall per bit
  task automatic send(input logic [31:0] w, input int n);
    tick(1);
    cs_n = 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      tick(2);
      sdi = w[i];
      tick(2);
      sclk = 1'b0;
      tick(4);
      sclk = 1'b1;
    end
    tick(4);
    cs_n = 1'b1;
    // Released line no longer shows the last bit
    sdi = ~sdi;
    tick(12);
  endtask
endmodule // qdu_host_model
`default_nettype wire

// ---- verif/qdu_update_ctrl_tb_top.sv ----
// Self-checking bench for the update control against a behavioural model.
// Assumes the host model in its own file and the design package.
`timescale 1ns/1ps
`default_nettype none
module qdu_update_ctrl_tb_top;
  import qdu_pkg::*;
  logic mclk = 1'b0;
  logic rstn = 1'b0;
  logic dev_rst_n = 1'b1;
  logic ldn = 1'b1; // Load strobe, active low
  logic pola = 1'b0;
  logic polb = 1'b1;
  wire logic cs_n, sclk, sdi;
  logic [3:0][15:0] latch_code;
  qdu_eff_t [3:0] eff_code;
  logic [3:0] gain_x4, chan_unipolar;
  logic [15:0] rd_data;
  logic rd_valid, in_reset;
  logic [3:0] uni;
  logic [1:0] ch;
  // Model state
  logic [15:0] m_in [4];
  logic [15:0] m_lat [4];
  int m_z [4];
  int m_g [4];
  logic [3:0] m_pend, m_gain;
  int fail_count = 0;
  int n_checks = 0;
  int rd_cnt = 0;
  int cyc = 0;
  int z;
  assign uni = {polb, polb, pola, pola};
  // 20 MHz clock
  initial forever #25 mclk = ~mclk;
  qdu_host_model host (.mclk(mclk), .cs_n(cs_n), .sclk(sclk), .sdi(sdi));
  qdu_update_ctrl dut (.mclk(mclk), .rstn(rstn), .dev_rst_n(dev_rst_n), .cs_n(cs_n), .sclk(sclk), .sdi(sdi),
    .latch_load_strobe_n(ldn), .group_a_polarity_select(pola), .group_b_polarity_select(polb),
    .latch_code(latch_code), .eff_code(eff_code), .gain_x4(gain_x4), .chan_unipolar(chan_unipolar),
    .rd_data(rd_data), .rd_valid(rd_valid), .in_reset(in_reset));
  // Count read pulses and cut a hang short
  always @(posedge mclk) begin
    cyc++;
    if (rd_valid === 1'b1) rd_cnt++;
    if (cyc == 30000) begin
      fail_count++;
      $display("Error %0t: run took too long", $time);
      print_verdict();
    end
  end
  task automatic print_verdict();
    $display("Counts: %0d checks, %0d mismatches", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #2;
  endtask
  // Model reset values
  task automatic m_reset();
    for (int c = 0; c < 4; c++) begin
      m_in[c] = 16'h0000;
      m_lat[c] = 16'h0000;
      m_z[c] = 0;
      m_g[c] = 0;
    end
    m_pend = 4'h0;
    m_gain = 4'hf;
  endtask
  // Load event: only pending channels reload
  task automatic m_load();
    for (int c = 0; c < 4; c++) if (m_pend[c]) m_lat[c] = m_in[c];
    m_pend = 4'h0;
  endtask
  // Write frame of n bits; fewer than 24 is lost, extra leading bits are junk
  task automatic wr(input logic [3:0] a, input logic [15:0] d, input int n);
    host.send({6'h00, 2'b10, 1'b0, 3'h0, a, d}, n);
    if (n < 24 || dev_rst_n == 1'b0) return;
    if (a == ADDR_CMD) begin
      m_gain = d[3:0];
      if (d[LATCH_LOAD_CMD_BIT]) m_load();
      if (d[CMD_RST_BIT]) m_reset();
    end else if (a[3:2] == BANK_IN) begin
      m_in[a[1:0]] = d;
      if (!ldn) m_lat[a[1:0]] = d;
      m_pend[a[1:0]] = ldn;
    end else if (a[3:2] == BANK_ZERO) m_z[a[1:0]] = $signed(d[8:0]);
    else if (a[3:2] == BANK_GAIN) m_g[a[1:0]] = $signed(d[7:0]);
  endtask
  // Read frame; readback in written format, one valid pulse
  task automatic rd(input logic [3:0] a);
    int n0;
    logic [15:0] e;
    n0 = rd_cnt;
    e = 16'h0000;
    if (a == ADDR_CMD) e = {12'h000, m_gain};
    else if (a[3:2] == BANK_IN) e = m_in[a[1:0]];
    else if (a[3:2] == BANK_ZERO) e = 16'(m_z[a[1:0]]);
    else if (a[3:2] == BANK_GAIN) e = 16'(m_g[a[1:0]]);
    host.send({8'h00, 1'b1, 3'h0, a, 16'h0000}, 24);
    chk(rd_cnt, n0 + 1);
    chk(rd_data, e);
  endtask
  task automatic strobe(input logic v);
    if (ldn && !v) m_load();
    ldn = v;
    tick(10);
  endtask
  // Compare every channel output with the model
  task automatic check_all();
    longint x, e;
    for (int c = 0; c < 4; c++) begin
      x = (uni[c] ? longint'(m_lat[c]) : longint'($signed(m_lat[c]))) * 8 + m_z[c];
      e = x + ((x * m_g[c]) >>> (uni[c] ? GAIN_SH_UNI : GAIN_SH_BIP));
      chk(latch_code[c], m_lat[c]);
      chk({{10{eff_code[c][21]}}, eff_code[c]}, e[31:0]);
    end
    chk(gain_x4, m_gain);
    chk(chan_unipolar, uni);
  endtask
  // Main sequence
  initial begin
    void'($urandom(32'hb9fa));
    repeat (12) @(posedge mclk);
    #2;
    rstn = 1'b1;
    tick(10);
    m_reset();
    chk(in_reset, 1'b0);
    check_all();
    $display("Test power-on done");
    // Buffered writes wait for a load event
    for (int c = 0; c < 4; c++) begin
      ch = 2'(c);
      wr({BANK_IN, ch}, 16'($urandom), 24);
      check_all();
      rd({BANK_IN, ch});
      if (c != 1) begin
        strobe(1'b0);
        check_all();
        strobe(1'b1);
      end
    end
    $display("Test buffered done");
    // Strobe held low: direct update of channel 0
    strobe(1'b0);
    wr({BANK_IN, 2'h0}, 16'($urandom), 24);
    check_all();
    strobe(1'b1);
    // Load bit with new gain bits in the same word
    wr({BANK_IN, 2'h1}, 16'($urandom), 24);
    wr(ADDR_CMD, 16'h0045, 24);
    check_all();
    rd(ADDR_CMD);
    $display("Test load modes done");
    // Short frame dropped, long frame keeps last 24 bits, unmapped write ignored
    wr({BANK_IN, 2'h0}, 16'h1234, 23);
    wr({BANK_IN, 2'h2}, 16'hbeef, 26);
    wr(4'h1, 16'($urandom), 24);
    rd({BANK_IN, 2'h0});
    rd({BANK_IN, 2'h2});
    rd(4'h1);
    check_all();
    $display("Test framing done");
    // Calibration codes in both polarity modes, with range ends
    for (int p = 0; p < 2; p++) begin
      pola = p[0];
      polb = ~p[0];
      for (int c = 0; c < 4; c++) begin
        ch = 2'(c);
        z = (c == 0) ? -256 : (c == 1) ? 255 : int'($urandom_range(511)) - 256;
        wr({BANK_ZERO, ch}, 16'(z), 24);
        z = (c == 0) ? 127 : (c == 1) ? -128 : int'($urandom_range(255)) - 128;
        wr({BANK_GAIN, ch}, 16'(z), 24);
        wr({BANK_IN, ch}, (c == 2) ? 16'hffff : 16'($urandom), 24);
        rd({BANK_ZERO, ch});
        rd({BANK_GAIN, ch});
      end
      strobe(1'b0);
      check_all();
      strobe(1'b1);
    end
    $display("Test calibration done");
    // Soft reset clears codes, sets gain bits to one and self-clears
    wr(ADDR_CMD, 16'h0080, 24);
    check_all();
    rd(ADDR_CMD);
    $display("Test soft reset done");
    // Reset pin: frame ignored while low
    wr({BANK_IN, 2'h0}, 16'h5a5a, 24);
    strobe(1'b0);
    strobe(1'b1);
    dev_rst_n = 1'b0;
    tick(6);
    m_reset();
    chk(in_reset, 1'b1);
    wr({BANK_IN, 2'h1}, 16'h7777, 24);
    check_all();
    dev_rst_n = 1'b1;
    tick(10);
    chk(in_reset, 1'b0);
    rd({BANK_IN, 2'h1});
    check_all();
    $display("Test reset pin done");
    print_verdict();
  end
endmodule // qdu_update_ctrl_tb_top
`default_nettype wire
